// ==== svm_delay.sv ====
// saturating run-time counter: done is high once run has held for limit cycles
// assumes limit_i is stable while run_i is high
`timescale 1ns/10ps
module svm_delay #(
   parameter int CW = 13
) (
   input  wire logic          mclk_i,
   input  wire logic          reset_i,
   input  wire logic          run_i,
   input  wire logic [CW-1:0] limit_i,
   output logic               done_o
);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;

   // restart whenever run drops, so a glitch never counts toward the delay
   always_comb begin
      next_count = count;
      if (!run_i) begin
         next_count = '0;
      end else if (count != limit_i) begin
         next_count = count + CW'(1);
      end
   end

   assign done_o = run_i && (count == limit_i);

   // ==========================================================
   // registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule

// ==== svm_pkg.sv ====
// constants, field layouts and carrier types shared by the supply monitor files
// assumes a 50 MHz system clock and a 32-bit avalon-mm register port
package svm_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam int         ADDR_W      = 4;
   localparam logic [3:0] OFF_CTRL    = 4'h0;
   localparam logic [3:0] OFF_STATUS  = 4'h4;
   localparam logic [3:0] OFF_MASK    = 4'h8;
   localparam logic [3:0] OFF_FORCE   = 4'hC;

   // ==========================================================
   // field positions
   localparam int BIT_FLAG    = 5;
   localparam int BIT_ENABLE  = 4;
   localparam int BIT_REQ     = 0;
   localparam int BIT_SETTLED = 1;

   // ==========================================================
   // values after reset
   localparam logic [2:0] RST_LEVEL  = 3'h0;
   localparam logic       RST_ENABLE = 1'b0;
   localparam logic       RST_MASK   = 1'b0;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS   = 20;
   localparam int IRQ_DELAY_NS    = 20000;
   localparam int IRQ_DELAY_CYC   = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STAB_DELAY_NS   = 100000;
   localparam int STAB_DELAY_CYC  = (STAB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W           = 13;

   // ==========================================================
   // trip levels in millivolts, index is the threshold select code
   localparam int MV_W = 13;
   localparam logic [7:0][MV_W-1:0] TRIP_MV = {
      13'h0FA0, 13'h0E10, 13'h0CE4, 13'h0BB8,
      13'h0A8C, 13'h0960, 13'h07D0, 13'h0708
   };

   // ==========================================================
   // carriers
   typedef struct packed {
      logic       detector_enable;
      logic [2:0] threshold_select;
   } svm_ctrl_t;

   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_ACK
   } svm_bus_state_t;

endpackage

// ==== svm_sync.sv ====
// two-stage synchroniser for one level
// assumes the input may change at any time relative to mclk_i
`timescale 1ns/10ps
module svm_sync (
   input  wire logic mclk_i,
   input  wire logic reset_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic stage1;
   logic next_stage1;
   logic next_q;

   // first stage feeds only the second one
   always_comb begin
      next_stage1 = d_i;
      next_q      = stage1;
   end

   // ==========================================================
   // registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         stage1 <= 1'b0;
         q_o    <= 1'b0;
      end else begin
         stage1 <= next_stage1;
         q_o    <= next_q;
      end
   end

endmodule

// ==== svm_tb.sv ====
// self-checking bench for the supply voltage monitor top: registers, flag, delayed irq, wake
// assumes svm_pkg and the design files are compiled first; the bench drives every port itself
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end

module svm_tb;
   // ==========================================================
   // signals and bench state
   localparam int STAB = 20;
   typedef struct packed {
      logic [2:0]  code;
      logic [7:0]  hot;
      logic [12:0] mv;
   } svm_row_t;
   logic        mclk_i;
   logic        reset_i;
   logic [3:0]  address_i;
   logic        read_i;
   logic        write_i;
   logic [31:0] writedata_i;
   logic [3:0]  byteenable_i;
   logic [31:0] readdata_o;
   logic        waitrequest_o;
   logic        comp_low_i;
   logic        sleep_i;
   logic        idle_i;
   logic        detector_on_o;
   logic [7:0]  level_onehot_o;
   logic [12:0] trip_mv_o;
   logic        irq_o;
   logic        wake_o;
   logic [31:0] rd;
   int          mismatches;
   int          check_count;
   int          cycles;
   int          wakes;
   int          w0;
   int          t0;
   svm_row_t    rows [8] = '{'{3'h0, 8'h01, 13'h0708}, '{3'h1, 8'h02, 13'h07D0},
      '{3'h2, 8'h04, 13'h0960}, '{3'h3, 8'h08, 13'h0A8C}, '{3'h4, 8'h10, 13'h0BB8},
      '{3'h5, 8'h20, 13'h0CE4}, '{3'h6, 8'h40, 13'h0E10}, '{3'h7, 8'h80, 13'h0FA0}};

   // short settle parameter keeps the run small; expectations use the same value
   svm_top #(.STAB_CYCLES(STAB)) svm_top_inst (
      .mclk_i(mclk_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .comp_low_i(comp_low_i),
      .sleep_i(sleep_i), .idle_i(idle_i), .detector_on_o(detector_on_o),
      .level_onehot_o(level_onehot_o), .trip_mv_o(trip_mv_o), .irq_o(irq_o), .wake_o(wake_o));

   // ==========================================================
   // clock, cycle count, wake count and hang guard
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (wake_o === 1'b1) begin
         wakes <= wakes + 1;
      end
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   // ==========================================================
   // bus and wait helpers
   // one avalon transfer; an edge always passes first so a new request never lands on a release
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk_i);
      read_i <= ~wr;
      write_i <= wr;
      address_i <= a;
      writedata_i <= d;
      do begin
         @(posedge mclk_i);
         k++;
      end while (waitrequest_o !== 1'b0 && k < 50);
      rd = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      `CHK("bus answer", 1'b1, k < 50)
   endtask

   // waits for the interrupt and checks how far it lies from the comparator rise
   task automatic wait_irq();
      while (irq_o !== 1'b1 && cycles - t0 < 1200) begin
         @(posedge mclk_i);
      end
      `CHK("irq delay", 1'b1, (cycles - t0 >= 1000) && (cycles - t0 <= 1010))
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {mismatches, check_count, cycles, wakes} = '0;
      {read_i, write_i, comp_low_i, sleep_i, idle_i} = '0;
      address_i = 4'h0;
      writedata_i = 32'h0;
      byteenable_i = 4'hF;
      reset_i = 1'b1;
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      `CHK("level after reset", 8'h01, level_onehot_o)
      `CHK("trip after reset", 13'h0708, trip_mv_o)
      `CHK("detector after reset", 1'b0, detector_on_o)
      `CHK("irq after reset", 1'b0, irq_o)
      bus(1'b0, svm_pkg::OFF_CTRL, 32'h0);
      `CHK("ctrl after reset", 32'h0, rd)
      bus(1'b0, svm_pkg::OFF_MASK, 32'h0);
      `CHK("mask after reset", 32'h0, rd)
      bus(1'b0, 4'h2, 32'h0);
      `CHK("unmapped read", 32'h0, rd)
      $display("test reset done");
      // every threshold code, with junk in the flag and spare bits that must not stick
      foreach (rows[i]) begin
         bus(1'b1, svm_pkg::OFF_CTRL, {24'h0, 5'h1F, rows[i].code});
         bus(1'b0, svm_pkg::OFF_CTRL, 32'h0);
         `CHK("ctrl readback", {24'h0, 5'h02, rows[i].code}, rd)
         `CHK("level onehot", rows[i].hot, level_onehot_o)
         `CHK("trip level", rows[i].mv, trip_mv_o)
      end
      $display("test table done");
      byteenable_i <= 4'h0;
      bus(1'b1, svm_pkg::OFF_CTRL, 32'h0);
      byteenable_i <= 4'hF;
      `CHK("detector on", 1'b1, detector_on_o)
      comp_low_i <= 1'b1;
      t0 = cycles;
      // synchroniser and flag register take three edges to pass the comparator
      repeat (3) @(posedge mclk_i);
      bus(1'b0, svm_pkg::OFF_CTRL, 32'h0);
      `CHK("flag high", 32'h37, rd)
      bus(1'b0, svm_pkg::OFF_STATUS, 32'h0);
      `CHK("settled no request", 32'h2, rd)
      $display("test flag done");
      bus(1'b1, svm_pkg::OFF_MASK, 32'h1);
      idle_i <= 1'b1;
      w0 = wakes;
      wait_irq();
      repeat (3) @(posedge mclk_i);
      `CHK("wake pulses", 1, wakes - w0)
      bus(1'b0, svm_pkg::OFF_STATUS, 32'h0);
      `CHK("status request", 32'h3, rd)
      bus(1'b1, svm_pkg::OFF_MASK, 32'h0);
      bus(1'b0, svm_pkg::OFF_MASK, 32'h0);
      `CHK("irq masked", 1'b0, irq_o)
      bus(1'b1, svm_pkg::OFF_MASK, 32'h1);
      bus(1'b1, svm_pkg::OFF_STATUS, 32'h1);
      bus(1'b0, svm_pkg::OFF_STATUS, 32'h0);
      `CHK("request cleared", 32'h2, rd)
      `CHK("irq cleared", 1'b0, irq_o)
      $display("test irq done");
      sleep_i <= 1'b1;
      bus(1'b0, svm_pkg::OFF_CTRL, 32'h0);
      `CHK("flag in sleep", 32'h17, rd)
      `CHK("detector in sleep", 1'b0, detector_on_o)
      $display("test sleep done");
      // a preset request must swallow the next event's wake while idle
      sleep_i <= 1'b0;
      bus(1'b1, svm_pkg::OFF_FORCE, 32'h1);
      w0 = wakes;
      repeat (1100) @(posedge mclk_i);
      `CHK("no wake when preset", 0, wakes - w0)
      bus(1'b0, svm_pkg::OFF_STATUS, 32'h0);
      `CHK("preset request", 32'h3, rd)
      $display("test force done");
      // a dip in the flag must restart the delay
      bus(1'b1, svm_pkg::OFF_STATUS, 32'h1);
      comp_low_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      comp_low_i <= 1'b1;
      repeat (600) @(posedge mclk_i);
      comp_low_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      `CHK("no irq on short stretch", 1'b0, irq_o)
      comp_low_i <= 1'b1;
      t0 = cycles;
      wait_irq();
      $display("test restart done");
      reset_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      bus(1'b0, svm_pkg::OFF_CTRL, 32'h0);
      `CHK("ctrl after second reset", 32'h0, rd)
      `CHK("irq after second reset", 1'b0, irq_o)
      // software must not trust the flag before the settle time has passed
      bus(1'b1, svm_pkg::OFF_CTRL, 32'h10);
      bus(1'b0, svm_pkg::OFF_STATUS, 32'h0);
      `CHK("not settled yet", 32'h0, rd)
      repeat (STAB) @(posedge mclk_i);
      bus(1'b0, svm_pkg::OFF_STATUS, 32'h0);
      `CHK("settled after delay", 32'h2, rd)
      bus(1'b0, svm_pkg::OFF_FORCE, 32'h0);
      `CHK("force reads zero", 32'h0, rd)
      $display("test rereset done");
      end_of_test();
   end
endmodule

// ==== svm_top.sv ====
// supply voltage monitor control: register port, flag, delayed interrupt, wake
// assumes the analog comparator sits outside and reports supply-below-trip
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module svm_top #(
   parameter int STAB_CYCLES = svm_pkg::STAB_DELAY_CYC
) (
   input  wire logic                         mclk_i,
   input  wire logic                         reset_i,
   input  wire logic [svm_pkg::ADDR_W-1:0]   address_i,
   input  wire logic                         read_i,
   input  wire logic                         write_i,
   input  wire logic [31:0]                  writedata_i,
   input  wire logic [3:0]                   byteenable_i,
   output logic      [31:0]                  readdata_o,
   output logic                              waitrequest_o,
   input  wire logic                         comp_low_i,
   input  wire logic                         sleep_i,
   input  wire logic                         idle_i,
   output logic                              detector_on_o,
   output logic      [7:0]                   level_onehot_o,
   output logic      [svm_pkg::MV_W-1:0]     trip_mv_o,
   output logic                              irq_o,
   output logic                              wake_o
);

   // ==========================================================
   // state
   svm_pkg::svm_bus_state_t state;
   svm_pkg::svm_bus_state_t next_state;
   svm_pkg::svm_ctrl_t      ctrl;
   svm_pkg::svm_ctrl_t      next_ctrl;
   logic [31:0]             next_readdata;
   logic                    next_wait;
   logic                    req_flag;
   logic                    next_req_flag;
   logic                    mask;
   logic                    next_mask;
   logic                    low_supply_flag;
   logic                    next_flag;
   logic                    next_detector_on;
   logic [7:0]              next_onehot;
   logic [svm_pkg::MV_W-1:0] next_trip;
   logic                    next_irq;
   logic                    next_wake;
   logic                    delay_done_q;
   logic                    comp_sync;
   logic                    delay_done;
   logic                    settled;
   logic                    active;
   logic                    take_wr;
   logic                    irq_event;
   logic                    force_set;
   logic                    req_clear;

   // ==========================================================
   // comparator crossing and delay counters
   svm_sync u_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .d_i     (comp_low_i),
      .q_o     (comp_sync)
   );

   // interrupt delay runs only while the flag stays high
   svm_delay #(.CW(svm_pkg::CNT_W)) u_irq_delay (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .run_i   (low_supply_flag),
      .limit_i (svm_pkg::CNT_W'(svm_pkg::IRQ_DELAY_CYC)),
      .done_o  (delay_done)
   );

   // settled only tells software the power-up delay has passed
   svm_delay #(.CW(svm_pkg::CNT_W)) u_stab_delay (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .run_i   (active),
      .limit_i (svm_pkg::CNT_W'(STAB_CYCLES)),
      .done_o  (settled)
   );

   // ==========================================================
   // detector control and flag
   always_comb begin
      active           = ctrl.detector_enable && !sleep_i;
      next_detector_on = active;
      next_flag        = active && comp_sync;
      next_trip        = svm_pkg::TRIP_MV[ctrl.threshold_select];
      next_onehot      = 8'h01 << ctrl.threshold_select;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         detector_on_o   <= 1'b0;
         low_supply_flag <= 1'b0;
         trip_mv_o       <= svm_pkg::TRIP_MV[svm_pkg::RST_LEVEL];
         level_onehot_o  <= 8'h01;
      end else begin
         detector_on_o   <= next_detector_on;
         low_supply_flag <= next_flag;
         trip_mv_o       <= next_trip;
         level_onehot_o  <= next_onehot;
      end
   end

   // ==========================================================
   // register bus: one wait cycle, write lands when waitrequest is low
   always_comb begin
      next_state    = state;
      next_wait     = 1'b1;
      next_readdata = readdata_o;
      next_ctrl     = ctrl;
      next_mask     = mask;
      take_wr       = (state == svm_pkg::BUS_ACK) && write_i && byteenable_i[0];
      unique case (state)
         svm_pkg::BUS_IDLE: begin
            if (read_i || write_i) begin
               next_state    = svm_pkg::BUS_ACK;
               next_wait     = 1'b0;
               next_readdata = 32'h0000_0000;
               if (read_i) begin
                  unique case (address_i)
                     svm_pkg::OFF_CTRL: begin
                        next_readdata[svm_pkg::BIT_FLAG]   = low_supply_flag;
                        next_readdata[svm_pkg::BIT_ENABLE] = ctrl.detector_enable;
                        next_readdata[2:0]                 = ctrl.threshold_select;
                     end
                     svm_pkg::OFF_STATUS: begin
                        next_readdata[svm_pkg::BIT_REQ]     = req_flag;
                        next_readdata[svm_pkg::BIT_SETTLED] = settled;
                     end
                     svm_pkg::OFF_MASK: begin
                        next_readdata[svm_pkg::BIT_REQ] = mask;
                     end
                     default: begin
                        next_readdata = 32'h0000_0000; // unmapped and force read zero
                     end
                  endcase
               end
            end
         end
         svm_pkg::BUS_ACK: begin
            next_state = svm_pkg::BUS_IDLE;
            if (take_wr && address_i == svm_pkg::OFF_CTRL) begin
               // flag bit is never stored, so a write cannot touch it
               next_ctrl.detector_enable  = writedata_i[svm_pkg::BIT_ENABLE];
               next_ctrl.threshold_select = writedata_i[2:0];
            end
            if (take_wr && address_i == svm_pkg::OFF_MASK) begin
               next_mask = writedata_i[svm_pkg::BIT_REQ];
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state         <= svm_pkg::BUS_IDLE;
         waitrequest_o <= 1'b1;
         readdata_o    <= 32'h0000_0000;
         ctrl          <= '{svm_pkg::RST_ENABLE, svm_pkg::RST_LEVEL};
         mask          <= svm_pkg::RST_MASK;
      end else begin
         state         <= next_state;
         waitrequest_o <= next_wait;
         readdata_o    <= next_readdata;
         ctrl          <= next_ctrl;
         mask          <= next_mask;
      end
   end

   // ==========================================================
   // interrupt request, output and idle wake
   always_comb begin
      irq_event = delay_done && !delay_done_q;
      force_set = take_wr && address_i == svm_pkg::OFF_FORCE && writedata_i[svm_pkg::BIT_REQ];
      req_clear = take_wr && address_i == svm_pkg::OFF_STATUS && writedata_i[svm_pkg::BIT_REQ];
      next_req_flag = req_flag;
      if (req_clear) begin
         next_req_flag = 1'b0;
      end
      // an event in the clearing cycle must survive
      if (irq_event || force_set) begin
         next_req_flag = 1'b1;
      end
      next_irq  = next_req_flag && next_mask;
      // only a fresh rise wakes, so a preset request keeps idle undisturbed
      next_wake = irq_event && !req_flag && idle_i;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         req_flag     <= 1'b0;
         delay_done_q <= 1'b0;
         irq_o        <= 1'b0;
         wake_o       <= 1'b0;
      end else begin
         req_flag     <= next_req_flag;
         delay_done_q <= delay_done;
         irq_o        <= next_irq;
         wake_o       <= next_wake;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   int unsigned hi_cnt;
   localparam int unsigned IRQ_MIN = svm_pkg::IRQ_DELAY_CYC;

   // helper: cycles the flag has been high
   always_ff @(posedge mclk_i) begin
      if (reset_i || !low_supply_flag) begin
         hi_cnt <= 0;
      end else if (hi_cnt < 32'hFFFF) begin
         hi_cnt <= hi_cnt + 1;
      end
   end

   AST_TRIP_DECODE: assert property (
      trip_mv_o == svm_pkg::TRIP_MV[$past(ctrl.threshold_select)]
      && level_onehot_o[$past(ctrl.threshold_select)])
      else $error("trip level does not match threshold select");

   AST_FLAG_FOLLOWS: assert property (
      $past(active) && $past(comp_sync) |-> low_supply_flag)
      else $error("flag not high while comparator reports low supply");

   AST_FLAG_READONLY: assert property (
      state == svm_pkg::BUS_ACK && $past(read_i) && $past(address_i) == svm_pkg::OFF_CTRL
      |-> readdata_o[svm_pkg::BIT_FLAG] == $past(low_supply_flag)
      && readdata_o[7:6] == 2'h0 && !readdata_o[3])
      else $error("control read shows wrong flag or reserved bits");

   AST_ENABLE_POWER: assert property (
      $rose(ctrl.detector_enable) && !sleep_i |=> detector_on_o)
      else $error("detector not powered after enable");

   AST_SLEEP_OFF: assert property (
      sleep_i |=> !detector_on_o ##0 !low_supply_flag)
      else $error("detector active during sleep");

   AST_IRQ_DELAY: assert property (
      $rose(delay_done_q) |-> hi_cnt >= IRQ_MIN)
      else $error("request raised before the delay elapsed");

   AST_IRQ_OUT: assert property (
      irq_o == (req_flag && mask))
      else $error("interrupt output does not follow request and mask");

   AST_IDLE_WAKE: assert property (
      irq_event && !req_flag && idle_i |=> wake_o ##1 !wake_o)
      else $error("no single wake pulse on new request in idle");

   AST_SYNC_DEPTH: assert property (
      !$past(reset_i, 2) && !$past(reset_i) |-> comp_sync == $past(comp_low_i, 2))
      else $error("comparator not delayed by two stages");

   AST_BUS_ANSWER: assert property (
      (read_i || write_i) && state == svm_pkg::BUS_IDLE |=> !waitrequest_o ##1 waitrequest_o)
      else $error("bus answer not given after one wait cycle");

   // a slave that drops waitrequest while idle would ack a request it never saw
   AST_WAIT_IDLE: assert property (
      state == svm_pkg::BUS_IDLE |-> waitrequest_o)
      else $error("waitrequest low while the bus is idle");

   AST_ONEHOT: assert property (
      $onehot(level_onehot_o))
      else $error("level select is not one-hot");

   AST_FLAG_LOW: assert property (
      !$past(active && comp_sync) |-> !low_supply_flag)
      else $error("flag high while detector off or supply above trip");

   AST_CTRL_HOLD: assert property (
      !$past(take_wr) |-> $stable(ctrl))
      else $error("control changed without a landed write");

   // the request bit moves only on an event, a force or a clear
   AST_REQ_SET: assert property (
      irq_event || force_set |=> req_flag)
      else $error("request flag missed its setting event");

   AST_REQ_QUIET: assert property (
      !req_flag && !irq_event && !force_set |=> !req_flag)
      else $error("request flag rose without an event");

   AST_REQ_STICKY: assert property (
      req_flag && !req_clear |=> req_flag)
      else $error("request flag dropped without a clear");

   AST_WAKE_FRESH: assert property (
      wake_o |-> $past(irq_event && !req_flag && idle_i))
      else $error("wake pulse without a fresh request in idle");

   COV_IRQ:    cover property ($rose(req_flag));
   COV_WAKE:   cover property (wake_o);
   COV_SLEEP:  cover property (ctrl.detector_enable && sleep_i);
   COV_SETTLE: cover property ($rose(settled));
   COV_PRESET: cover property (force_set && !req_flag);

endmodule
